// >>> rtl/sar_regs.svh
// Register map, field positions, reset values and timing counts of the
// converter sequencer. Included by the top module, the input model and the bench.
`ifndef SAR_REGS_SVH
`define SAR_REGS_SVH

// ----------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------
`define SAR_CTRL_OFF     8'h00
`define SAR_CHEN_OFF     8'h04
`define SAR_LIMIT_OFF    8'h08
`define SAR_STAT_OFF     8'h0c
`define SAR_MASK_OFF     8'h10
`define SAR_STATE_OFF    8'h14
`define SAR_SMP0_OFF     8'h18
`define SAR_SMP1_OFF     8'h1c
`define SAR_SMP2_OFF     8'h20
`define SAR_RES_BASE     8'h80

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define SAR_CTRL_RUN     0
`define SAR_CTRL_CONT    1
`define SAR_CTRL_FW      2
`define SAR_CTRL_FWGO    3
`define SAR_CTRL_FWCH    4
`define SAR_CTRL_REF     12
`define SAR_CTRL_EXT16   14
`define SAR_LIMIT_HI     16
`define SAR_ST_DONE      0
`define SAR_ST_SCAN      1
`define SAR_ST_OOR       2
`define SAR_STATE_CH     4
`define SAR_STATE_LP     9
`define SAR_STATE_RES    16

// ----------------------------------------------------------------------
// Sizes and reset values
// ----------------------------------------------------------------------
`define SAR_NCH          17
`define SAR_TEMP_CH      5'h10
`define SAR_BASE_MASK    17'h100ff
`define SAR_LO_RST       12'h000
`define SAR_HI_RST       12'hfff
`define SAR_RESP_OK      2'b00
`define SAR_RESP_ERR     2'b10

// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
`define SAR_CLK_MHZ      25
`define SAR_CONV_MAX_MHZ 18
// Double the least divider so the comparator synchroniser settles in a bit
`define SAR_CONV_DIV     (((`SAR_CLK_MHZ + `SAR_CONV_MAX_MHZ - 1) / `SAR_CONV_MAX_MHZ) * 2)
`define SAR_MIN_CLOCKS   18
`define SAR_BITS         12
`define SAR_TAIL         2
`define SAR_SAMPLE_MIN   (`SAR_MIN_CLOCKS - `SAR_BITS - `SAR_TAIL)

`endif

// >>> rtl/sar_pkg.sv
// Types shared by the converter sequencer files.
// Assumes sar_regs.svh is on the include path.
package sar_pkg;
  typedef enum logic [1:0] {
    SQ_IDLE,
    SQ_SAMPLE,
    SQ_CONV,
    SQ_TAIL
  } sar_state_type;
endpackage : sar_pkg

// >>> rtl/sar_mem.sv
// Result buffer: one write port, one read port with registered data.
// Assumes the writer and reader share aclk and the clock enable.
`timescale 1ns/1ns
`default_nettype none
module sar_mem (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic        ce,
  input  wire logic        we,
  input  wire logic [4:0]  waddr,
  input  wire logic [11:0] wdata,
  input  wire logic        re,
  input  wire logic [4:0]  raddr,
  output logic      [11:0] rdata
);
  logic [11:0] mem_r [0:16];
  logic [11:0] rdata_nxt;

  always_comb begin
    rdata_nxt = rdata;
    if (re) begin
      rdata_nxt = (raddr <= 5'h10) ? mem_r[raddr] : 12'h000;
    end
  end

  // Array carries no reset; an entry not written since reset holds no defined value
  always_ff @(posedge aclk) begin
    if (ce && we && (waddr <= 5'h10)) begin
      mem_r[waddr] <= wdata;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rdata <= 12'h000;
    end else if (ce) begin
      rdata <= rdata_nxt;
    end
  end
endmodule : sar_mem
`default_nettype wire

// >>> rtl/sar_ctrl.sv
// Converter sequencer with AXI4-Lite registers, per-channel results,
// range check and interrupt.
// Assumes a single 25 MHz aclk; cmp_i is asynchronous, lp_deep_i is on aclk.
// How it works
// - Each conversion spends at least 18 converter ticks from sampling to result.
// - The converter tick is aclk divided down so it never exceeds 18 MHz.
// - Channels 0 to 7 and 16 are scanned, and setting ext16 opens channels 8 to 15.
// - A started scan walks all enabled channels without software help.
// - The next channel starts sampling on the very tick that the last ends.
// - Channel choice comes from the scanner or from a firmware-written number.
// - Every channel has its own result slot readable at any time.
// - Each channel has its own sample length, applied when it is converted.
// - Software sets low and high limits and every result is compared.
// - An out-of-range result sets its interrupt flag at once, mid scan.
// - A two-bit field picks supply, half supply, bandgap or external ref.
// - The sample-and-hold window grows with the programmed sample length.
// - A deep low-power request aborts conversion and blocks new starts.
// - Channel 16 selects the temperature sensor like any pin channel.
`timescale 1ns/1ns
`default_nettype none
`include "sar_regs.svh"
module sar_ctrl (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic        ce,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic        cmp_i,
  input  wire logic        lp_deep_i,
  output logic [4:0]       mux_sel_o,
  output logic             sample_o,
  output logic [11:0]      dac_o,
  output logic [1:0]       ref_sel_o,
  output logic             busy_o,
  output logic             irq_o
);
  // --------------------------------------------------------------------
  // Declarations
  // --------------------------------------------------------------------
  logic [7:0]  awaddr_r, awaddr_nxt, raddr_r, raddr_nxt;
  logic        awhave_r, awhave_nxt, whave_r, whave_nxt, rpend_r, rpend_nxt;
  logic [31:0] wdata_r, wdata_nxt, rdata_nxt;
  logic [3:0]  wstrb_r, wstrb_nxt;
  logic        awready_nxt, wready_nxt, arready_nxt, bvalid_nxt, rvalid_nxt;
  logic [1:0]  bresp_nxt, rresp_nxt;
  logic        run_r, run_nxt, cont_r, cont_nxt, fw_r, fw_nxt, fwgo_r, fwgo_nxt;
  logic        ext16_r, ext16_nxt, irq_nxt;
  logic [4:0]  fwch_r, fwch_nxt;
  logic [1:0]  ref_r, ref_nxt;
  logic [16:0] chen_r, chen_nxt, allow;
  logic [11:0] lo_r, lo_nxt, hi_r, hi_nxt, last_r, last_nxt, mem_rdata;
  logic [2:0]  stat_r, stat_nxt, mask_r, mask_nxt, stat_set;
  logic [3:0]  stime_r [0:16];
  logic [31:0] wimg;
  logic        do_wr;
  sar_pkg::sar_state_type st_r, st_nxt;
  logic [4:0]  ch_r, ch_nxt, cnt_r, cnt_nxt;
  logic [3:0]  bit_r, bit_nxt;
  logic [11:0] dac_nxt;
  logic        sample_nxt, mem_we, finish, oor;
  logic [5:0]  pick_next, pick_first;
  logic [1:0]  div_r, div_nxt;
  logic        tick, cs1_r, cs2_r, cs3_r, cmpf_r, cmpf_nxt;
  logic [5:0]  cvt_r, cvt_nxt;

  function automatic logic [31:0] sar_merge(input logic [31:0] o, input logic [31:0] w,
                                            input logic [3:0] s);
    logic [31:0] m;
    m = {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
    return (o & ~m) | (w & m);
  endfunction : sar_merge

  // Lowest enabled channel at or above the start index
  function automatic logic [5:0] sar_pick(input logic [16:0] m, input logic [5:0] from);
    logic [5:0] r;
    r = 6'h00;
    for (int i = 16; i >= 0; i--) begin
      if (m[i] && (6'(i) >= from)) begin
        r = {1'b1, 5'(i)};
      end
    end
    return r;
  endfunction : sar_pick

  function automatic logic [31:0] sar_img(input logic [7:0] a);
    logic [31:0] v;
    v = 32'h0000_0000;
    case (a)
      `SAR_CTRL_OFF: begin
        v[`SAR_CTRL_RUN] = run_r;
        v[`SAR_CTRL_CONT] = cont_r;
        v[`SAR_CTRL_FW] = fw_r;
        v[`SAR_CTRL_FWGO] = fwgo_r;
        v[`SAR_CTRL_FWCH +: 5] = fwch_r;
        v[`SAR_CTRL_REF +: 2] = ref_r;
        v[`SAR_CTRL_EXT16] = ext16_r;
      end
      `SAR_CHEN_OFF:  v[16:0] = chen_r;
      `SAR_LIMIT_OFF: v = {4'h0, hi_r, 4'h0, lo_r};
      `SAR_STAT_OFF:  v[2:0] = stat_r;
      `SAR_MASK_OFF:  v[2:0] = mask_r;
      `SAR_STATE_OFF: begin
        v[0] = busy_o;
        v[`SAR_STATE_CH +: 5] = ch_r;
        v[`SAR_STATE_LP] = lp_deep_i;
        v[`SAR_STATE_RES +: 12] = last_r;
      end
      `SAR_SMP0_OFF: v = {stime_r[7], stime_r[6], stime_r[5], stime_r[4],
                          stime_r[3], stime_r[2], stime_r[1], stime_r[0]};
      `SAR_SMP1_OFF: v = {stime_r[15], stime_r[14], stime_r[13], stime_r[12],
                          stime_r[11], stime_r[10], stime_r[9], stime_r[8]};
      `SAR_SMP2_OFF: v[3:0] = stime_r[16];
      default: v = 32'h0000_0000;
    endcase
    return v;
  endfunction : sar_img

  function automatic logic sar_mapped(input logic [7:0] a);
    return (a <= `SAR_SMP2_OFF && a[1:0] == 2'b00) ||
           (a[7] && a[6:2] <= 5'h10 && a[1:0] == 2'b00);
  endfunction : sar_mapped

  // --------------------------------------------------------------------
  // Result buffer
  // --------------------------------------------------------------------
  sar_mem u_mem (
    .aclk    (aclk),
    .aresetn (aresetn),
    .ce      (ce),
    .we      (mem_we),
    .waddr   (ch_r),
    .wdata   (dac_nxt),
    .re      (s_axi_arvalid && s_axi_arready),
    .raddr   (s_axi_araddr[6:2]),
    .rdata   (mem_rdata)
  );

  // --------------------------------------------------------------------
  // Register bus and register file
  // --------------------------------------------------------------------
  assign do_wr = awhave_r && whave_r && !s_axi_bvalid;
  // Process form so the image follows every register that it merges with
  always_comb begin
    wimg = sar_merge(sar_img(awaddr_r), wdata_r, wstrb_r);
  end

  always_comb begin
    awaddr_nxt = awaddr_r;  awhave_nxt = awhave_r;  wdata_nxt = wdata_r;
    wstrb_nxt = wstrb_r;    whave_nxt = whave_r;    bvalid_nxt = s_axi_bvalid;
    bresp_nxt = s_axi_bresp; raddr_nxt = raddr_r;   rpend_nxt = rpend_r;
    rvalid_nxt = s_axi_rvalid; rresp_nxt = s_axi_rresp; rdata_nxt = s_axi_rdata;
    run_nxt = run_r;  cont_nxt = cont_r;  fw_nxt = fw_r;  fwgo_nxt = fwgo_r;
    fwch_nxt = fwch_r;  ref_nxt = ref_r;  ext16_nxt = ext16_r;  chen_nxt = chen_r;
    lo_nxt = lo_r;  hi_nxt = hi_r;  mask_nxt = mask_r;  stat_nxt = stat_r;
    if (s_axi_awvalid && s_axi_awready) begin
      awaddr_nxt = s_axi_awaddr;
      awhave_nxt = 1'b1;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      wdata_nxt = s_axi_wdata;
      wstrb_nxt = s_axi_wstrb;
      whave_nxt = 1'b1;
    end
    if (s_axi_bvalid && s_axi_bready) begin
      bvalid_nxt = 1'b0;
    end
    if (do_wr) begin
      awhave_nxt = 1'b0;
      whave_nxt = 1'b0;
      bvalid_nxt = 1'b1;
      bresp_nxt = sar_mapped(awaddr_r) ? `SAR_RESP_OK : `SAR_RESP_ERR;
      case (awaddr_r)
        `SAR_CTRL_OFF: begin
          run_nxt = wimg[`SAR_CTRL_RUN];
          cont_nxt = wimg[`SAR_CTRL_CONT];
          fw_nxt = wimg[`SAR_CTRL_FW];
          fwgo_nxt = wimg[`SAR_CTRL_FWGO];
          fwch_nxt = wimg[`SAR_CTRL_FWCH +: 5];
          ref_nxt = wimg[`SAR_CTRL_REF +: 2];
          ext16_nxt = wimg[`SAR_CTRL_EXT16];
        end
        `SAR_CHEN_OFF:  chen_nxt = wimg[16:0];
        `SAR_LIMIT_OFF: begin
          lo_nxt = wimg[11:0];
          hi_nxt = wimg[`SAR_LIMIT_HI +: 12];
        end
        `SAR_STAT_OFF:  stat_nxt = stat_r & ~(wdata_r[2:0] & {3{wstrb_r[0]}});
        `SAR_MASK_OFF:  mask_nxt = wimg[2:0];
        default: ;
      endcase
    end
    // Hardware events win over a simultaneous clear
    stat_nxt = stat_nxt | stat_set;
    if (st_r == sar_pkg::SQ_IDLE && fwgo_r && fw_r && !lp_deep_i) begin
      fwgo_nxt = 1'b0;
    end
    if (lp_deep_i) begin
      run_nxt = 1'b0;
    end else if (finish && !fw_r && !pick_next[5] && !(cont_r && run_r)) begin
      run_nxt = 1'b0;
    end else if (st_r == sar_pkg::SQ_IDLE && !fw_r && run_r && !pick_first[5]) begin
      run_nxt = 1'b0;
    end
    if (s_axi_rvalid && s_axi_rready) begin
      rvalid_nxt = 1'b0;
    end
    if (s_axi_arvalid && s_axi_arready) begin
      raddr_nxt = s_axi_araddr;
      rpend_nxt = 1'b1;
    end
    // Slot data is one cycle behind the address, so reads finish here
    if (rpend_r) begin
      rpend_nxt = 1'b0;
      rvalid_nxt = 1'b1;
      rresp_nxt = sar_mapped(raddr_r) ? `SAR_RESP_OK : `SAR_RESP_ERR;
      rdata_nxt = raddr_r[7] ? {20'h0_0000, mem_rdata} : sar_img(raddr_r);
    end
    awready_nxt = !awhave_nxt && !bvalid_nxt;
    wready_nxt = !whave_nxt && !bvalid_nxt;
    arready_nxt = !rpend_nxt && !rvalid_nxt;
    irq_nxt = |(stat_nxt & mask_nxt);
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awaddr_r <= 8'h00;  awhave_r <= 1'b0;  wdata_r <= 32'h0000_0000;
      wstrb_r <= 4'h0;  whave_r <= 1'b0;  raddr_r <= 8'h00;  rpend_r <= 1'b0;
      s_axi_awready <= 1'b0;  s_axi_wready <= 1'b0;  s_axi_arready <= 1'b0;
      s_axi_bvalid <= 1'b0;  s_axi_bresp <= `SAR_RESP_OK;  s_axi_rvalid <= 1'b0;
      s_axi_rresp <= `SAR_RESP_OK;  s_axi_rdata <= 32'h0000_0000;
      run_r <= 1'b0;  cont_r <= 1'b0;  fw_r <= 1'b0;  fwgo_r <= 1'b0;
      fwch_r <= 5'h00;  ref_r <= 2'h0;  ext16_r <= 1'b0;  chen_r <= 17'h0_0000;
      lo_r <= `SAR_LO_RST;  hi_r <= `SAR_HI_RST;  stat_r <= 3'h0;  mask_r <= 3'h0;
      irq_o <= 1'b0;  ref_sel_o <= 2'h0;
    end else if (ce) begin
      awaddr_r <= awaddr_nxt;  awhave_r <= awhave_nxt;  wdata_r <= wdata_nxt;
      wstrb_r <= wstrb_nxt;  whave_r <= whave_nxt;  raddr_r <= raddr_nxt;
      rpend_r <= rpend_nxt;  s_axi_awready <= awready_nxt;
      s_axi_wready <= wready_nxt;  s_axi_arready <= arready_nxt;
      s_axi_bvalid <= bvalid_nxt;  s_axi_bresp <= bresp_nxt;
      s_axi_rvalid <= rvalid_nxt;  s_axi_rresp <= rresp_nxt;  s_axi_rdata <= rdata_nxt;
      run_r <= run_nxt;  cont_r <= cont_nxt;  fw_r <= fw_nxt;  fwgo_r <= fwgo_nxt;
      fwch_r <= fwch_nxt;  ref_r <= ref_nxt;  ext16_r <= ext16_nxt;  chen_r <= chen_nxt;
      lo_r <= lo_nxt;  hi_r <= hi_nxt;  stat_r <= stat_nxt;  mask_r <= mask_nxt;
      irq_o <= irq_nxt;
      ref_sel_o <= ref_nxt;
    end
  end

  // Per-channel sample lengths, four bits each
  for (genvar g = 0; g < `SAR_NCH; g++) begin : g_stime
    localparam logic [7:0] OFF = (g < 8) ? `SAR_SMP0_OFF :
                                 (g < 16) ? `SAR_SMP1_OFF : `SAR_SMP2_OFF;
    logic [3:0] nxt;
    always_comb begin
      nxt = stime_r[g];
      if (do_wr && awaddr_r == OFF) begin
        nxt = wimg[(g % 8) * 4 +: 4];
      end
    end
    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        stime_r[g] <= 4'h0;
      end else if (ce) begin
        stime_r[g] <= nxt;
      end
    end
  end

  // --------------------------------------------------------------------
  // Converter tick, comparator synchroniser and sequencer
  // --------------------------------------------------------------------
  assign tick = (div_r == 2'(`SAR_CONV_DIV - 1));
  assign allow = ext16_r ? chen_r : (chen_r & `SAR_BASE_MASK);
  assign pick_next = sar_pick(allow, {1'b0, ch_r} + 6'h01);
  assign pick_first = sar_pick(allow, 6'h00);
  assign finish = (st_r == sar_pkg::SQ_TAIL) && tick && (cnt_r == 5'h00) && !lp_deep_i;
  assign mem_we = finish;
  assign oor = (dac_o < lo_r) || (dac_o > hi_r);
  assign stat_set = {finish && oor, finish && !fw_r && !pick_next[5], finish};

  always_comb begin
    div_nxt = tick ? 2'h0 : div_r + 2'h1;
    cmpf_nxt = (cs2_r == cs3_r) ? cs3_r : cmpf_r;
    st_nxt = st_r;  ch_nxt = ch_r;  cnt_nxt = cnt_r;  bit_nxt = bit_r;
    dac_nxt = dac_o;  sample_nxt = sample_o;  last_nxt = last_r;
    cvt_nxt = (st_r == sar_pkg::SQ_IDLE || finish) ? 6'h00 :
              (tick && cvt_r != 6'h3f) ? cvt_r + 6'h01 : cvt_r;
    case (st_r)
      sar_pkg::SQ_IDLE: begin
        if (!lp_deep_i && fw_r && fwgo_r && fwch_r <= `SAR_TEMP_CH) begin
          st_nxt = sar_pkg::SQ_SAMPLE;
          ch_nxt = fwch_r;
        end else if (!lp_deep_i && !fw_r && run_r && pick_first[5]) begin
          st_nxt = sar_pkg::SQ_SAMPLE;
          ch_nxt = pick_first[4:0];
        end
      end
      sar_pkg::SQ_SAMPLE: begin
        if (tick) begin
          if (cnt_r == 5'h00) begin
            st_nxt = sar_pkg::SQ_CONV;
            sample_nxt = 1'b0;
            bit_nxt = 4'(`SAR_BITS - 1);
            dac_nxt = 12'h800;
          end else begin
            cnt_nxt = cnt_r - 5'h01;
          end
        end
      end
      sar_pkg::SQ_CONV: begin
        if (tick) begin
          // Agreed sync value: the registered copy lags the trial by a cycle
          if (!cmpf_nxt) begin
            dac_nxt[bit_r] = 1'b0;
          end
          if (bit_r == 4'h0) begin
            st_nxt = sar_pkg::SQ_TAIL;
            cnt_nxt = 5'(`SAR_TAIL - 1);
          end else begin
            dac_nxt[bit_r - 4'h1] = 1'b1;
            bit_nxt = bit_r - 4'h1;
          end
        end
      end
      sar_pkg::SQ_TAIL: begin
        if (tick && cnt_r != 5'h00) begin
          cnt_nxt = cnt_r - 5'h01;
        end else if (finish) begin
          last_nxt = dac_o;
          st_nxt = sar_pkg::SQ_IDLE;
          if (!fw_r && run_r && pick_next[5]) begin
            st_nxt = sar_pkg::SQ_SAMPLE;
            ch_nxt = pick_next[4:0];
          end else if (!fw_r && run_r && cont_r && pick_first[5]) begin
            st_nxt = sar_pkg::SQ_SAMPLE;
            ch_nxt = pick_first[4:0];
          end
        end
      end
      default: st_nxt = sar_pkg::SQ_IDLE;
    endcase
    if (st_r != sar_pkg::SQ_SAMPLE && st_nxt == sar_pkg::SQ_SAMPLE ||
        finish && st_nxt == sar_pkg::SQ_SAMPLE) begin
      sample_nxt = 1'b1;
      cnt_nxt = 5'(`SAR_SAMPLE_MIN - 1) + {1'b0, stime_r[ch_nxt]};
    end
    if (lp_deep_i) begin
      st_nxt = sar_pkg::SQ_IDLE;
      sample_nxt = 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      div_r <= 2'h0;  cs1_r <= 1'b0;  cs2_r <= 1'b0;  cs3_r <= 1'b0;  cmpf_r <= 1'b0;
      st_r <= sar_pkg::SQ_IDLE;  ch_r <= 5'h00;  cnt_r <= 5'h00;  bit_r <= 4'h0;
      dac_o <= 12'h000;  sample_o <= 1'b0;  last_r <= 12'h000;  mux_sel_o <= 5'h00;
      busy_o <= 1'b0;  cvt_r <= 6'h00;
    end else if (ce) begin
      div_r <= div_nxt;  cs1_r <= cmp_i;  cs2_r <= cs1_r;  cs3_r <= cs2_r;
      cmpf_r <= cmpf_nxt;  st_r <= st_nxt;  ch_r <= ch_nxt;  cnt_r <= cnt_nxt;
      bit_r <= bit_nxt;  dac_o <= dac_nxt;  sample_o <= sample_nxt;  last_r <= last_nxt;
      mux_sel_o <= ch_nxt;
      busy_o <= (st_nxt != sar_pkg::SQ_IDLE);
      cvt_r <= cvt_nxt;
    end
  end

  // --------------------------------------------------------------------
  // Assertions
  // --------------------------------------------------------------------
  a_conv_length: assert property (@(posedge aclk) disable iff (!aresetn)
    mem_we |-> cvt_r >= 6'd17) else $error("conversion shorter than 18 ticks");
  a_tick_rate: assert property (@(posedge aclk) disable iff (!aresetn)
    ce && tick |=> !tick) else $error("converter tick above rate limit");
  a_no_gap: assert property (@(posedge aclk) disable iff (!aresetn)
    ce && finish && !fw_r && run_r && pick_next[5] |=> st_r == sar_pkg::SQ_SAMPLE && sample_o)
    else $error("idle gap between channels");
  a_oor_flag: assert property (@(posedge aclk) disable iff (!aresetn)
    ce && finish && oor |=> stat_r[`SAR_ST_OOR]) else $error("range flag not set");
  a_flag_sticky: assert property (@(posedge aclk) disable iff (!aresetn)
    ce && stat_r[`SAR_ST_OOR] && !(do_wr && awaddr_r == `SAR_STAT_OFF)
    |=> stat_r[`SAR_ST_OOR]) else $error("range flag dropped by itself");
  a_lp_stop: assert property (@(posedge aclk) disable iff (!aresetn)
    ce && lp_deep_i |=> st_r == sar_pkg::SQ_IDLE && !sample_o && !run_r)
    else $error("converter active in deep low power");
  a_irq_level: assert property (@(posedge aclk) disable iff (!aresetn)
    ce |=> irq_o == |(stat_r & mask_r)) else $error("irq mismatch");
  a_ref_follow: assert property (@(posedge aclk) disable iff (!aresetn)
    ce && do_wr && awaddr_r == `SAR_CTRL_OFF && wstrb_r[1]
    |=> ref_sel_o == $past(wdata_r[`SAR_CTRL_REF +: 2])) else $error("reference not applied");
  a_chan_limit: assert property (@(posedge aclk) disable iff (!aresetn)
    sample_o && !ext16_r && !fw_r |-> mux_sel_o < 5'h08 || mux_sel_o == `SAR_TEMP_CH)
    else $error("upper channel scanned without ext16");
  a_sample_min: assert property (@(posedge aclk) disable iff (!aresetn)
    ce && $rose(st_r == sar_pkg::SQ_CONV) |-> cvt_r >= 6'(`SAR_SAMPLE_MIN)
    + {2'b00, stime_r[ch_r]}) else $error("sample window too short");
endmodule : sar_ctrl
`default_nettype wire

// >>> sim/sar_ain_model.sv
// Far-side model: analog inputs as the comparator sees them.
// Assumes mux_sel and dac come from the sequencer on aclk.
`timescale 1ns/1ns
`default_nettype none
`include "sar_regs.svh"
module sar_ain_model (
  input  wire logic [4:0]  mux_sel,
  input  wire logic [11:0] dac,
  output logic             cmp
);
  logic [11:0] level;
  // Each pin sits at a level of its own so a wrong channel shows
  assign level = (mux_sel == `SAR_TEMP_CH) ? 12'h7c3 : {mux_sel[3:0], 8'h5a};
  assign cmp   = (level >= dac);
endmodule : sar_ain_model
`default_nettype wire

// >>> sim/sar_adc_sequencer_control_tb.sv
// Self-checking bench: AXI4-Lite tasks and one task per scenario.
// Assumes sar_ctrl, its register header and the analog input model.
`timescale 1ns/1ns
`default_nettype none
`include "sar_regs.svh"
module sar_adc_sequencer_control_tb;
  logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, lp;
  logic        awready, wready, bvalid, arready, rvalid, cmp, smp, busy, irq;
  logic [7:0]  awaddr, araddr;
  logic [31:0] wdata, rdata, v;
  logic [1:0]  bresp, rresp, rsel, r;
  logic [4:0]  sel;
  logic [11:0] dac;
  int          fail_count, compares, n;
  sar_ctrl dut_u (.aclk(aclk), .aresetn(aresetn), .ce(1'b1), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .cmp_i(cmp),
    .lp_deep_i(lp), .mux_sel_o(sel), .sample_o(smp), .dac_o(dac), .ref_sel_o(rsel),
    .busy_o(busy), .irq_o(irq));
  sar_ain_model ain_u (.mux_sel(sel), .dac(dac), .cmp(cmp));
  task chk(input string what, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e) begin
      fail_count++;
      $display("Error %s expected %h seen %h", what, e, g);
    end
  endtask : chk
  task wr(input logic [7:0] a, input logic [31:0] d);
    awaddr <= a;
    wdata <= d;
    {awvalid, wvalid, bready} <= 3'b111;
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid);
    // bready and rready stay high, so no edge sees them dropped and raised at once
  endtask : wr
  task rd(input logic [7:0] a);
    araddr <= a;
    {arvalid, rready} <= 2'b11;
    do begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
    end while (!rvalid);
    v = rdata;
    r = rresp;
  endtask : rd
  // Counts busy cycles until the sequencer goes idle again
  task idle;
    repeat (3000) begin
      @(posedge aclk);
      if (busy) n++;
      else if (n > 0) break;
    end
  endtask : idle
  task t_regs;
    rd(`SAR_LIMIT_OFF);
    chk("limit", 32'h0fff0000, v);
    rd(8'h40);
    chk("unmapped", `SAR_RESP_ERR, r);
  endtask : t_regs
  task t_fw;
    logic [4:0] c [5] = '{5'h00, 5'h07, 5'h08, 5'h0f, 5'h10};
    for (int i = 0; i < 5; i++) begin
      wr(`SAR_CTRL_OFF, 32'h400c | (i[1:0] << 12) | (c[i] << 4));
      n = 0;
      idle;
      // 18 ticks of 4 cycles; the start phase against the tick moves it by up to 3
      chk("clocks", 1, n >= 69 && n <= 72);
      chk("ref", i[1:0], rsel);
      rd(`SAR_RES_BASE + 8'(4 * c[i]));
      chk("fw_res", c[i][4] ? 32'h7c3 : {c[i][3:0], 8'h5a}, v);
    end
  endtask : t_fw
  task t_scan;
    wr(`SAR_LIMIT_OFF, 32'h02ff0150);
    wr(`SAR_SMP0_OFF, 32'h30);
    wr(`SAR_CHEN_OFF, 32'hf);
    wr(`SAR_MASK_OFF, 32'h4);
    wr(`SAR_STAT_OFF, 32'h7);
    wr(`SAR_CTRL_OFF, 32'h1);
    n = 0;
    repeat (1000) begin
      @(posedge aclk);
      n += busy;
      if (irq) break;
    end
    chk("irq_set", 1, irq);
    chk("irq_mid", 1, busy);
    idle;
    chk("scan_clk", 1, n >= 297 && n <= 300);
    for (int i = 0; i < 4; i++) begin
      rd(`SAR_RES_BASE + 8'(4 * i));
      chk("scan_res", {i[3:0], 8'h5a}, v);
    end
    rd(`SAR_STAT_OFF);
    chk("stat", 32'h7, v);
    wr(`SAR_STAT_OFF, 32'h4);
    repeat (2) @(posedge aclk);
    chk("irq_clr", 0, irq);
  endtask : t_scan
  task t_cont;
    wr(`SAR_CHEN_OFF, 32'h1);
    wr(`SAR_CTRL_OFF, 32'h3);
    repeat (200) @(posedge aclk);
    chk("cont", 1, busy);
    wr(`SAR_CTRL_OFF, 32'h0);
    n = 0;
    idle;
    chk("cont_stop", 1, n <= 72);
  endtask : t_cont
  task t_lp;
    wr(`SAR_CTRL_OFF, 32'h2c);
    @(posedge aclk);
    chk("smp", 1, smp);
    chk("mux", 5'h02, sel);
    repeat (19) @(posedge aclk);
    lp <= 1'b1;
    repeat (3) @(posedge aclk);
    chk("abort", 0, busy);
    chk("lp_smp", 0, smp);
    wr(`SAR_CTRL_OFF, 32'h2c);
    repeat (10) @(posedge aclk);
    chk("blocked", 0, busy);
  endtask : t_lp
  task end_of_test;
    if (fail_count == 0 && compares > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : end_of_test
  initial begin
    aclk = 1'b0;
    forever #20 aclk = ~aclk;
  end
  initial begin
    repeat (20000) @(posedge aclk);
    fail_count++;
    end_of_test;
  end
  initial begin
    {aresetn, awvalid, wvalid, bready, arvalid, rready, lp, awaddr, araddr, wdata} = '0;
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    t_regs;
    t_fw;
    t_scan;
    t_cont;
    t_lp;
    end_of_test;
  end
endmodule : sar_adc_sequencer_control_tb
`default_nettype wire
